//--- rtl/dcr_device_end.sv
// device end: serial frame receiver and command interpreter
// assumes the host clocks the link well below the core rate (half period >= 8 core cycles)
// Summary of operation
// - every configuration command answers one acknowledge byte
// - save command pulses a copy-to-nonvolatile request
// - power-down bit zero selects standby
// - reference bit zero selects external lock
// - bit one enables ref output, bit two rate
// - bit three enables backplane clock export
// - trim command drives sixteen-bit tuning word
// - plan command applies 48-bit value by code
// - loop command sets two-bit synth gain
// - calibration start acknowledges immediately
// - user nonvolatile write of byte at address
// - host writes query before reading response
// - responses are eight bytes, MSB first
// - host reads all eight response bytes
// - operating-value query uses four-bit selector
// - thermal query returns 32 bits, upper zero
// - status bits 7..0 report lock states
// - status bits 9..13 and 16 mirror configuration
// - identity query uses four-bit selector
// - nonvolatile reads take 16-bit start address
// - readout frame gives 64 clocks for response
// - address byte leads every frame
// - busy device drops ready and ignores bytes
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module dcr_device_end #(
   parameter int BUSY_CYC = dcr_pkg::BUSY_CYCLES
) (
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   dcr_link_if.dev          link_if,
   input  wire logic [7:0]  lock_status_in,
   input  wire logic [31:0] temperature_in,
   input  wire logic        device_accessed_in,
   input  wire logic        second_stage_filter_choice_in,
   input  wire logic        input_amp_on_in,
   input  wire logic        automatic_amp_control_in,
   input  wire logic        auto_gain_on_in,
   input  wire logic [63:0] query_data_in,
   input  wire logic        query_valid_in,
   output logic             standby_out,
   output logic             external_ref_lock_out,
   output logic             ref_output_on_out,
   output logic             ref_output_rate_select_out,
   output logic             backplane_clock_export_out,
   output logic [15:0]      trim_word_out,
   output logic [1:0]       synth_gain_setting_out,
   output logic             save_startup_out,
   output logic             calibration_start_out,
   output logic             nvm_write_out,
   output logic [15:0]      nvm_addr_out,
   output logic [7:0]       nvm_data_out,
   output logic             plan_write_out,
   output logic [2:0]       plan_select_out,
   output logic [47:0]      plan_value_out,
   output logic             query_req_out,
   output logic [7:0]       query_code_out,
   output logic [15:0]      query_arg_out
);
   import dcr_pkg::*;

   typedef enum logic [2:0] {D_IDLE = 3'b001, D_WAIT = 3'b010, D_BUSY = 3'b100} dcr_dstate_e;

   dcr_dstate_e st_q;
   logic [2:0]  sclk_s;
   logic [2:0]  cs_s;
   logic [1:0]  mosi_s;
   logic        active_q;
   logic [2:0]  bit_q;
   logic [3:0]  byte_q;
   logic [7:0]  addr_q;
   logic [63:0] in_q;
   logic [63:0] out_q;
   logic [63:0] resp_q;
   logic [15:0] busy_q;
   logic        stby_q;
   logic [3:0]  ref_q;
   logic [15:0] trim_q;
   logic [1:0]  gain_q;

   // link pins come from another domain: two flops before any use
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sclk_s <= 3'h0;
         cs_s   <= 3'h7;
         mosi_s <= 2'h0;
      end else begin
         sclk_s <= {sclk_s[1:0], link_if.sclk};
         cs_s   <= {cs_s[1:0], link_if.cs_n};
         mosi_s <= {mosi_s[0], link_if.mosi};
      end
   end

   wire        sclk_rise = sclk_s[1] & ~sclk_s[2];
   wire        sclk_fall = ~sclk_s[1] & sclk_s[2];
   wire        cs_fall   = ~cs_s[1] & cs_s[2];
   wire        cs_rise   = cs_s[1] & ~cs_s[2];
   wire [55:0] dat       = in_q[55:0];
   wire        len_ok    = (byte_q == dcr_frame_len(addr_q)) && (bit_q == 3'h0);
   wire        go        = cs_rise & active_q & len_ok;
   wire        is_cfg    = (addr_q >= CMD_SAVE) && (addr_q <= CMD_NVW);
   wire        is_fwd    = (addr_q == Q_OPER) || (addr_q == Q_IDENT) || (addr_q == Q_CALRD) || (addr_q == Q_NVRD);
   wire        is_sel    = (addr_q == Q_OPER) || (addr_q == Q_IDENT);
   wire [19:0] cond_bits = {auto_gain_on_in, automatic_amp_control_in, input_amp_on_in, stby_q, 1'b0,
                            second_stage_filter_choice_in, gain_q, ref_q[2], ref_q[1], ref_q[0],
                            device_accessed_in, lock_status_in};

   // frame capture; a frame opened while busy is dropped whole
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         active_q <= 1'b0;
         bit_q    <= 3'h0;
         byte_q   <= 4'h0;
         addr_q   <= 8'h00;
         in_q     <= 64'h0;
         out_q    <= 64'h0;
      end else if (cs_fall) begin
         active_q <= (st_q == D_IDLE);
         bit_q    <= 3'h0;
         byte_q   <= 4'h0;
         out_q    <= resp_q;
      end else if (cs_rise) begin
         active_q <= 1'b0;
      end else if (active_q && sclk_rise) begin
         in_q  <= {in_q[62:0], mosi_s[1]};
         bit_q <= bit_q + 3'h1;
         if (bit_q == 3'h7) begin
            if (byte_q == 4'h0) begin
               addr_q <= {in_q[6:0], mosi_s[1]};
            end
            if (byte_q != 4'hf) begin
               byte_q <= byte_q + 4'h1;
            end
         end
      end else if (active_q && sclk_fall) begin
         out_q <= {out_q[62:0], 1'b0};
      end
   end

   assign link_if.miso              = out_q[63];
   assign link_if.serial_ready_flag = (st_q == D_IDLE);

   // settings that persist
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stby_q <= 1'b0;
         ref_q  <= REF_RST;
         trim_q <= TRIM_RST;
         gain_q <= GAIN_RST;
      end else if (go) begin
         if (addr_q == CMD_PWR) stby_q <= dat[PWR_STBY_BIT];
         if (addr_q == CMD_REF) ref_q <= dat[REF_BITS-1:0];
         if (addr_q == CMD_TRIM) trim_q <= dat[TRIM_W-1:0];
         // code 3 has no defined gain, so it leaves the setting alone
         if (addr_q == CMD_LOOP && dat[GAIN_W-1:0] != GAIN_BAD) gain_q <= dat[GAIN_W-1:0];
      end
   end

   assign standby_out                = stby_q;
   assign external_ref_lock_out      = ref_q[0];
   assign ref_output_on_out          = ref_q[1];
   assign ref_output_rate_select_out = ref_q[2];
   assign backplane_clock_export_out = ref_q[3];
   assign trim_word_out              = trim_q;
   assign synth_gain_setting_out     = gain_q;

   // one-cycle requests to the user side with their data
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         save_startup_out      <= 1'b0;
         calibration_start_out <= 1'b0;
         nvm_write_out         <= 1'b0;
         plan_write_out        <= 1'b0;
         query_req_out         <= 1'b0;
         nvm_addr_out          <= 16'h0;
         nvm_data_out          <= 8'h0;
         plan_select_out       <= 3'h0;
         plan_value_out        <= 48'h0;
         query_code_out        <= 8'h0;
         query_arg_out         <= 16'h0;
      end else begin
         save_startup_out      <= go && addr_q == CMD_SAVE;
         calibration_start_out <= go && addr_q == CMD_CAL;
         nvm_write_out         <= go && addr_q == CMD_NVW;
         plan_write_out        <= go && addr_q == CMD_PLAN && dat[PLAN_SEL_LSB+2:PLAN_SEL_LSB] <= PLAN_SEL_MAX;
         query_req_out         <= go && is_fwd;
         if (go && addr_q == CMD_NVW) begin
            nvm_addr_out <= dat[NVW_ADDR_LSB+15:NVW_ADDR_LSB];
            nvm_data_out <= dat[7:0];
         end
         if (go && addr_q == CMD_PLAN) begin
            plan_select_out <= dat[PLAN_SEL_LSB+2:PLAN_SEL_LSB];
            plan_value_out  <= dat[PLAN_W-1:0];
         end
         if (go && is_fwd) begin
            query_code_out <= addr_q;
            query_arg_out  <= is_sel ? {12'h0, dat[SEL_W-1:0]} : dat[15:0];
         end
      end
   end

   // response word and busy sequencing
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         resp_q <= 64'h0;
         st_q   <= D_IDLE;
         busy_q <= 16'h0;
      end else begin
         if (go && is_cfg) resp_q <= {ACK_BYTE, 56'h0};
         else if (go && addr_q == Q_THERM) resp_q <= {32'h0, temperature_in};
         else if (go && addr_q == Q_COND) resp_q <= {44'h0, cond_bits};
         else if (st_q == D_WAIT && query_valid_in) resp_q <= query_data_in;
         case (st_q)
            D_IDLE: begin
               busy_q <= 16'h0;
               if (go) st_q <= is_fwd ? D_WAIT : D_BUSY;
            end
            D_WAIT: begin
               if (query_valid_in) st_q <= D_BUSY;
            end
            D_BUSY: begin
               busy_q <= busy_q + 16'h1;
               if (busy_q == 16'(BUSY_CYC - 1)) st_q <= D_IDLE;
            end
            default: st_q <= D_IDLE;
         endcase
      end
   end
endmodule : dcr_device_end

//--- rtl/dcr_pkg.sv
// constants shared by both ends of the downconverter command link
// assumes a 40 MHz core clock on both ends
package dcr_pkg;
   // command and query addresses (first byte of every frame)
   localparam logic [7:0] CMD_SAVE    = 8'h16;
   localparam logic [7:0] CMD_PWR     = 8'h17;
   localparam logic [7:0] CMD_REF     = 8'h18;
   localparam logic [7:0] CMD_TRIM    = 8'h19;
   localparam logic [7:0] CMD_PLAN    = 8'h1a;
   localparam logic [7:0] CMD_LOOP    = 8'h1b;
   localparam logic [7:0] CMD_CAL     = 8'h1c;
   localparam logic [7:0] CMD_NVW     = 8'h1d;
   localparam logic [7:0] Q_OPER      = 8'h20;
   localparam logic [7:0] Q_THERM     = 8'h21;
   localparam logic [7:0] Q_COND      = 8'h22;
   localparam logic [7:0] Q_IDENT     = 8'h23;
   localparam logic [7:0] Q_CALRD     = 8'h24;
   localparam logic [7:0] Q_NVRD      = 8'h25;
   localparam logic [7:0] CMD_READOUT = 8'h26;
   localparam logic [7:0] ACK_BYTE    = 8'h00;
   // field positions inside frame data
   localparam int PWR_STBY_BIT = 0;
   localparam int REF_BITS     = 4;
   localparam int TRIM_W       = 16;
   localparam int GAIN_W       = 2;
   localparam int PLAN_SEL_LSB = 48;
   localparam int PLAN_W       = 48;
   localparam int NVW_ADDR_LSB = 8;
   localparam int SEL_W        = 4;
   localparam logic [2:0] PLAN_SEL_MAX = 3'h6;
   localparam logic [1:0] GAIN_BAD     = 2'h3;
   // reset values
   localparam logic [3:0] REF_RST  = 4'h0;
   localparam logic [1:0] GAIN_RST = 2'h1;
   localparam logic [15:0] TRIM_RST = 16'h0000;
   // timing: periods in ns, counts in core cycles
   localparam int CORE_NS         = 25;
   localparam int LINK_HALF_NS    = 200;
   localparam int HALF_CLK_CYCLES = LINK_HALF_NS / CORE_NS;
   localparam int BUSY_CYCLES     = 16;
   // host register offsets on apb
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_DLO  = 8'h04;
   localparam logic [7:0] A_DHI  = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0c;
   localparam logic [7:0] A_RHI  = 8'h10;
   localparam logic [7:0] A_RLO  = 8'h14;

   // frame length in bytes including the address byte, 0 when unknown
   function automatic logic [3:0] dcr_frame_len(input logic [7:0] a);
      case (a)
         CMD_SAVE, CMD_PWR, CMD_REF, CMD_LOOP, CMD_CAL,
         Q_OPER, Q_THERM, Q_COND, Q_IDENT: return 4'h2;
         CMD_TRIM, CMD_NVW, Q_CALRD, Q_NVRD: return 4'h4;
         CMD_PLAN, CMD_READOUT: return 4'h8;
         default: return 4'h0;
      endcase
   endfunction : dcr_frame_len
endpackage : dcr_pkg

//--- rtl/dcr_link_if.sv
// serial link between the command host and the downconverter device
// the bench joins both modports; no clocking block here
`timescale 1ns/1ps
interface dcr_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic serial_ready_flag;
   modport dev (input sclk, input cs_n, input mosi, output miso, output serial_ready_flag);
   modport host (output sclk, output cs_n, output mosi, input miso, input serial_ready_flag);
endinterface : dcr_link_if

//--- rtl/dcr_host_end.sv
// host end: apb-programmed frame sender that makes the link clock
// assumes the device end samples the link with its own core clock
`timescale 1ns/1ps
module dcr_host_end #(
   parameter int HALF_CYC = dcr_pkg::HALF_CLK_CYCLES
) (
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   dcr_link_if.host         link_if
);
   import dcr_pkg::*;

   typedef enum logic [4:0] {H_IDLE = 5'b00001, H_LOW = 5'b00010, H_HIGH = 5'b00100,
                             H_TAIL = 5'b01000, H_GAP = 5'b10000} dcr_hstate_e;

   dcr_hstate_e st_q;
   logic [7:0]  caddr_q;
   logic [55:0] data_q;
   logic [63:0] resp_q;
   logic [63:0] tx_q;
   logic [63:0] rx_q;
   logic [6:0]  bits_q;
   logic [15:0] cnt_q;
   logic        pend_q;
   logic        err_q;
   logic        sclk_q;
   logic        cs_n_q;
   logic        mosi_q;
   logic [1:0]  miso_s;
   logic [1:0]  rdy_s;

   wire        acc     = psel_in & penable_in;
   wire        wr      = acc & pwrite_in;
   wire        hit     = paddr_in == A_CTRL || paddr_in == A_DLO || paddr_in == A_DHI ||
                         paddr_in == A_STAT || paddr_in == A_RHI || paddr_in == A_RLO;
   wire        busy    = pend_q | (st_q != H_IDLE);
   wire [3:0]  wlen    = dcr_frame_len(pwdata_in[7:0]);
   wire [3:0]  clen    = dcr_frame_len(caddr_q);
   wire [5:0]  sh      = {3'(4'h8 - clen), 3'h0};
   wire        tick    = cnt_q == 16'(HALF_CYC - 1);
   wire        start   = (st_q == H_IDLE) && pend_q && rdy_s[1];
   wire [31:0] stat_w  = {29'h0, err_q, rdy_s[1], busy};

   assign prdata_out = (paddr_in == A_CTRL) ? {24'h0, caddr_q} :
                       (paddr_in == A_DLO)  ? data_q[31:0] :
                       (paddr_in == A_DHI)  ? {8'h0, data_q[55:32]} :
                       (paddr_in == A_STAT) ? stat_w :
                       (paddr_in == A_RHI)  ? resp_q[63:32] :
                       (paddr_in == A_RLO)  ? resp_q[31:0] : 32'h0;
   assign pready_out  = 1'b1;
   assign pslverr_out = acc & ~hit;

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         miso_s <= 2'h0;
         rdy_s  <= 2'h0;
      end else begin
         miso_s <= {miso_s[0], link_if.miso};
         rdy_s  <= {rdy_s[0], link_if.serial_ready_flag};
      end
   end

   // software side: a ctrl write queues one frame; refused while busy or unknown
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         caddr_q <= 8'h00;
         data_q  <= 56'h0;
         pend_q  <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         if (start) pend_q <= 1'b0;
         if (wr && paddr_in == A_DLO) data_q[31:0] <= pwdata_in;
         if (wr && paddr_in == A_DHI) data_q[55:32] <= pwdata_in[23:0];
         if (wr && paddr_in == A_CTRL) begin
            if (busy || wlen == 4'h0) begin
               err_q <= 1'b1;
            end else begin
               err_q   <= 1'b0;
               pend_q  <= 1'b1;
               caddr_q <= pwdata_in[7:0];
            end
         end
      end
   end

   // link clock divider and shifter; mosi changes on fall, miso taken on rise
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q   <= H_IDLE;
         cnt_q  <= 16'h0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         mosi_q <= 1'b0;
         tx_q   <= 64'h0;
         rx_q   <= 64'h0;
         bits_q <= 7'h0;
         resp_q <= 64'h0;
      end else begin
         cnt_q <= (st_q == H_IDLE || tick) ? 16'h0 : cnt_q + 16'h1;
         case (st_q)
            H_IDLE: begin
               if (start) begin
                  cs_n_q <= 1'b0;
                  tx_q   <= {caddr_q, data_q << sh};
                  mosi_q <= caddr_q[7];
                  bits_q <= 7'({clen, 3'h0});
                  st_q   <= H_LOW;
               end
            end
            H_LOW: begin
               if (tick) begin
                  sclk_q <= 1'b1;
                  rx_q   <= {rx_q[62:0], miso_s[1]};
                  st_q   <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (tick) begin
                  sclk_q <= 1'b0;
                  bits_q <= bits_q - 7'h1;
                  tx_q   <= {tx_q[62:0], 1'b0};
                  mosi_q <= tx_q[62];
                  st_q   <= (bits_q == 7'h1) ? H_TAIL : H_LOW;
               end
            end
            H_TAIL: begin
               if (tick) begin
                  cs_n_q <= 1'b1;
                  st_q   <= H_GAP;
               end
            end
            H_GAP: begin
               // gap lets the device's ready drop reach us before the next start
               if (tick) begin
                  if (caddr_q == CMD_READOUT) resp_q <= rx_q;
                  st_q <= H_IDLE;
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   assign link_if.sclk = sclk_q;
   assign link_if.cs_n = cs_n_q;
   assign link_if.mosi = mosi_q;
endmodule : dcr_host_end

//--- test/dcr_monitor.sv
// wire-level checks on the serial link joining the host end and device end
// assumes both ends run with their default half period and busy count
`timescale 1ns/1ps
module dcr_monitor (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic serial_ready_flag
);
   logic [7:0] nb_q;

   // link clock rises per frame; frame length must be 2, 4 or 8 bytes
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         nb_q <= 8'h00;
      end else if ($fell(cs_n)) begin
         nb_q <= 8'h00;
      end else if ($rose(sclk)) begin
         nb_q <= nb_q + 8'h01;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence high_s;
      sclk [*8] ##1 !sclk;
   endsequence

   idle_clk_a : assert property (cs_n |-> !sclk)
      else $error("link clock high outside a frame");
   start_ready_a : assert property ($fell(cs_n) |-> serial_ready_flag && $past(serial_ready_flag, 2))
      else $error("frame started while device not ready");
   mosi_hold_a : assert property (sclk |-> $stable(mosi))
      else $error("host data moved while link clock high");
   miso_hold_a : assert property (sclk && !cs_n |-> $stable(miso))
      else $error("device data moved while link clock high");
   clk_high_a : assert property ($rose(sclk) |-> high_s)
      else $error("link clock high phase wrong length");
   bit_count_a : assert property ($rose(cs_n) |-> nb_q inside {8'h10, 8'h20, 8'h40})
      else $error("frame bit count not a whole frame");
   ready_drop_a : assert property ($rose(cs_n) |-> ##[1:8] !serial_ready_flag)
      else $error("device stayed ready after a frame");
   busy_hold_a : assert property ($fell(serial_ready_flag) |=> !serial_ready_flag [*8])
      else $error("device ready again too soon");
endmodule : dcr_monitor

//--- test/tb.sv
// self-checking bench: apb drives the host end, which talks to the device end
// assumes default half period and busy count; query data always valid
`timescale 1ns/1ps
module tb;
   import dcr_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, lock = 8'h3c;
   logic [31:0] pwdata = 32'h0, temp = 32'h41c8_0000, prdata, stat;
   logic        pready, pslverr, qv = 1'b1;
   logic        acc = 1'b1, filt = 1'b1, amp = 1'b0, aa = 1'b1, ag = 1'b0;
   logic [63:0] qdata = 64'h0, osh, msh;
   logic        stby, xlock, rout, rrate, bpx, psave, pcal, pnvw, pplan, pq;
   logic [15:0] trim, naddr, qarg;
   logic [7:0]  ndata, qcode;
   logic [1:0]  gain;
   logic [2:0]  psl;
   logic [47:0] pval;
   int          pc[5] = '{default: 0};
   int          n_fail = 0;
   int          cmp_count = 0;
   wire  [4:0]  pv = {pq, pplan, pnvw, pcal, psave};

   always #12.5 clk = ~clk;
   dcr_link_if lk();
   dcr_host_end dcr_host_end_inst (.core_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .link_if(lk.host));
   dcr_device_end dcr_device_end_inst (.core_clk_in(clk), .reset_n_in(rst_n), .link_if(lk.dev),
      .lock_status_in(lock), .temperature_in(temp), .device_accessed_in(acc),
      .second_stage_filter_choice_in(filt), .input_amp_on_in(amp), .automatic_amp_control_in(aa),
      .auto_gain_on_in(ag), .query_data_in(qdata), .query_valid_in(qv), .standby_out(stby),
      .external_ref_lock_out(xlock), .ref_output_on_out(rout), .ref_output_rate_select_out(rrate),
      .backplane_clock_export_out(bpx), .trim_word_out(trim), .synth_gain_setting_out(gain),
      .save_startup_out(psave), .calibration_start_out(pcal), .nvm_write_out(pnvw), .nvm_addr_out(naddr),
      .nvm_data_out(ndata), .plan_write_out(pplan), .plan_select_out(psl), .plan_value_out(pval),
      .query_req_out(pq), .query_code_out(qcode), .query_arg_out(qarg));
   dcr_monitor dcr_monitor_inst (.core_clk_in(clk), .reset_n_in(rst_n), .sclk(lk.sclk), .cs_n(lk.cs_n),
      .mosi(lk.mosi), .miso(lk.miso), .serial_ready_flag(lk.serial_ready_flag));

   // pulse outputs last one cycle, so they are counted rather than polled
   always @(posedge clk) foreach (pc[i]) pc[i] <= pc[i] + int'(pv[i]);
   always @(posedge lk.sclk) if (!lk.cs_n) begin
      osh <= {osh[62:0], lk.mosi};
      msh <= {msh[62:0], lk.miso};
   end

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // request held until the rising edge that sees pready high; the answer is taken at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_idle;
      logic e;
      stat = 32'h1;
      while (stat[0] !== 1'b0) apb(1'b0, A_STAT, 32'h0, stat, e);
   endtask : wait_idle

   task automatic send(input logic [7:0] a, input logic [55:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, A_DLO, d[31:0], r, e);
      apb(1'b1, A_DHI, {8'h00, d[55:32]}, r, e);
      apb(1'b1, A_CTRL, {24'h0, a}, r, e);
      wait_idle();
   endtask : send

   task automatic q(input logic [7:0] a, input logic [55:0] d, input logic [63:0] x);
      logic [31:0] hi, lo;
      logic e;
      send(a, d);
      send(CMD_READOUT, 56'h0);
      apb(1'b0, A_RHI, 32'h0, hi, e);
      apb(1'b0, A_RLO, 32'h0, lo, e);
      chk("response", x, {hi, lo});
      chk("miso bits", x, msh);
   endtask : q

   task automatic t_ref;
      wait_idle();
      chk("reset state", 11'h201, {stat[2:0], stby, xlock, rout, rrate, bpx, pc[0] != 0, gain});
      send(CMD_REF, 56'hf5);
      chk("ref bits", 4'h5, {bpx, rrate, rout, xlock});
      chk("frame on wire", {CMD_REF, 8'hf5}, osh[15:0]);
      chk("idle levels", 2'b01, {lk.sclk, lk.cs_n});
      send(CMD_REF, 56'h0a);
      chk("ref bits", 4'ha, {bpx, rrate, rout, xlock});
      q(CMD_CAL, 56'h0, {ACK_BYTE, 56'h0});
      chk("cal pulse", 1, pc[1]);
      $display("test ref done");
   endtask : t_ref

   task automatic t_cfg;
      send(CMD_PWR, 56'hfe);
      chk("standby", 1'b0, stby);
      send(CMD_PWR, 56'h01);
      chk("standby", 1'b1, stby);
      send(CMD_TRIM, 56'hab_1234);
      chk("trim", 16'h1234, trim);
      send(CMD_SAVE, 56'h0);
      chk("save pulse", 1, pc[0]);
      send(CMD_NVW, 56'hbe_ef5a);
      chk("nvm write", {16'hbeef, 8'h5a, 8'h01}, {naddr, ndata, 8'(pc[2])});
      for (int c = 0; c < 8; c++) begin
         send(CMD_PLAN, {5'h1f, 3'(c), 48'h1234_5678_9a00 + 48'(c)});
         chk("plan count", (c < 7) ? c + 1 : 7, pc[3]);
         if (c < 7) chk("plan value", {3'(c), 48'h1234_5678_9a00 + 48'(c)}, {psl, pval});
      end
      for (int g = 0; g < 4; g++) begin
         send(CMD_LOOP, {54'h0, 2'(g)});
         chk("gain", (g == 3) ? 2'h2 : 2'(g), gain);
      end
      $display("test cfg done");
   endtask : t_cfg

   task automatic t_query;
      logic [7:0]  a;
      logic [63:0] x;
      for (int s = 0; s < 12; s++) begin
         a = (s < 9) ? Q_OPER : Q_IDENT;
         x = {48'h00c0_ffee_0000, a, 8'(s)};
         qdata <= x;
         q(a, {52'h0, 4'(s < 9 ? s : s - 9)} | 56'ha0, x);
         chk("query code", {a, 12'h0, 4'(s < 9 ? s : s - 9)}, {qcode, qarg});
      end
      for (int i = 0; i < 2; i++) begin
         a = (i != 0) ? Q_NVRD : Q_CALRD;
         x = 64'h0807_0605_0403_0201 + 64'(i);
         qdata <= x;
         q(a, 56'h77_beef, x);
         chk("nvm read", {a, 16'hbeef}, {qcode, qarg});
      end
      chk("query pulses", 14, pc[4]);
      q(Q_THERM, 56'h0, {32'h0, temp});
      q(Q_COND, 56'h0, {44'h0, ag, aa, amp, 1'b1, 1'b0, filt, 2'h2, 1'b0, 1'b1, 1'b0, acc, lock});
      // status word left a nonzero response, so the acknowledge byte must replace it
      q(CMD_LOOP, 56'h01, {ACK_BYTE, 56'h0});
      $display("test query done");
   endtask : t_query

   task automatic t_err;
      logic [31:0] r;
      logic e;
      send(8'h30, 56'h0);
      chk("unknown address", 2'b11, {stat[2], stby});
      apb(1'b0, 8'h18, 32'h0, r, e);
      chk("unmapped slverr", 1'b1, e);
      apb(1'b1, A_DLO, 32'h0, r, e);
      apb(1'b1, A_CTRL, {24'h0, CMD_PWR}, r, e);
      apb(1'b1, A_CTRL, {24'h0, CMD_PWR}, r, e);
      wait_idle();
      chk("busy refusal", 2'b10, {stat[2], stby});
      $display("test err done");
   endtask : t_err

   task automatic conclude;
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_ref();
      t_cfg();
      t_query();
      t_err();
      conclude();
   end

   // the scenarios need about 40k cycles; twice that means a hang
   initial begin
      repeat (80000) @(posedge clk);
      n_fail++;
      conclude();
   end
endmodule : tb
